// ---- hw/ddc_consts.vh ----
`ifndef DDC_CONSTS_VH
`define DDC_CONSTS_VH

// Channel register window: 32 bytes per channel, byte address = ch * 32 + offset * 4.
`define DDC_CH_SHIFT 5
`define DDC_NUM_CH 14
`define DDC_OFF_CFG 3'h0
`define DDC_OFF_CNT 3'h1
`define DDC_OFF_SRC 3'h2
`define DDC_OFF_DST 3'h3
`define DDC_OFF_STAT 3'h4
`define DDC_OFF_REM 3'h5

// Configuration register fields.
`define DDC_CFG_EN 0
`define DDC_CFG_CIRC 1
`define DDC_CFG_PRIO 3:2
`define DDC_CFG_SSIZE 5:4
`define DDC_CFG_DSIZE 7:6
`define DDC_CFG_SINC 8
`define DDC_CFG_DINC 9
`define DDC_CFG_TRIG 11:10
`define DDC_CFG_RST 16'h0000

// Status register fields, write one to clear.
`define DDC_ST_HT 0
`define DDC_ST_TC 1
`define DDC_ST_TE 2

// Item sizes.
`define DDC_SZ_BYTE 2'h0
`define DDC_SZ_HALF 2'h1
`define DDC_SZ_WORD 2'h2

// Trigger sources.
`define DDC_TRIG_HW 2'h0
`define DDC_TRIG_SW 2'h1
`define DDC_TRIG_TMR 2'h2

// Count register width, large enough for 65536 items.
`define DDC_CW 17
`define DDC_CNT_MAX 17'h10000

`endif

// ---- hw/ddc_top.v ----
`timescale 1ns/100ps
`include "ddc_consts.vh"

module ddc_top #(
    parameter NCH = 7
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [8:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    output wire m_cyc_o,
    output wire m_stb_o,
    output wire m_we_o,
    output wire [31:0] m_adr_o,
    output wire [3:0] m_sel_o,
    output wire [31:0] m_dat_o,
    input wire [31:0] m_dat_i,
    input wire m_ack_i,
    input wire m_err_i,
    input wire [2*NCH-1:0] dreq_i,
    output wire [2*NCH-1:0] dack_o,
    input wire [2*NCH-1:0] timer_units_trig_i,
    input wire stop_mode_i,
    output wire [2*NCH-1:0] irq_o
);

    localparam NT = 2 * NCH;
    localparam ST_IDLE = 2'h0;
    localparam ST_RD = 2'h1;
    localparam ST_GAP = 2'h2;
    localparam ST_WR = 2'h3;

    // Per-channel state, one entry per channel of both controllers.
    reg [15:0] cfg_q [0:NT-1];
    reg [`DDC_CW-1:0] cnt_q [0:NT-1];
    reg [31:0] src_q [0:NT-1];
    reg [31:0] dst_q [0:NT-1];
    reg [31:0] csrc_q [0:NT-1];
    reg [31:0] cdst_q [0:NT-1];
    reg [`DDC_CW-1:0] rem_q [0:NT-1];
    reg [2:0] flg_q [0:NT-1];
    reg [NT-1:0] tpend_q;
    reg [NT-1:0] irq_q;
    reg [NT-1:0] dack_q;

    // Bus slave and master registers.
    reg wb_ack_q;
    reg [31:0] wb_dat_q;
    reg m_cyc_q;
    reg m_we_q;
    reg [31:0] m_adr_q;
    reg [3:0] m_sel_q;
    reg [31:0] m_dat_q;
    reg [1:0] st_q;
    reg [3:0] ch_q;
    reg last_ctl_q;
    reg [31:0] buf_q;

    reg [NT-1:0] req;
    reg [2*NT-1:0] prio;
    reg [3:0] g0;
    reg [3:0] g1;
    reg grant_v;
    reg [3:0] grant_ch;
    reg grant_ctl;
    integer k;

    // Byte lanes that an item of the given size at the given address occupies.
    function [3:0] lanes;
        input [1:0] sz;
        input [1:0] a;
        begin
            case (sz)
                `DDC_SZ_BYTE: lanes = 4'h1 << a;
                `DDC_SZ_HALF: lanes = a[1] ? 4'hc : 4'h3;
                default: lanes = 4'hf;
            endcase
        end
    endfunction

    // Address step of one item.
    function [31:0] step;
        input [1:0] sz;
        begin
            case (sz)
                `DDC_SZ_BYTE: step = 32'h1;
                `DDC_SZ_HALF: step = 32'h2;
                default: step = 32'h4;
            endcase
        end
    endfunction

    // Pulls an item down to bit 0 and zero-extends it to a word.
    function [31:0] extract;
        input [31:0] d;
        input [1:0] sz;
        input [1:0] a;
        reg [31:0] s;
        begin
            s = d >> {a, 3'h0};
            case (sz)
                `DDC_SZ_BYTE: extract = {24'h0, s[7:0]};
                `DDC_SZ_HALF: extract = {16'h0, s[15:0]};
                default: extract = d;
            endcase
        end
    endfunction

    // Copies an item onto every lane so the byte enables pick the right one.
    function [31:0] place;
        input [31:0] d;
        input [1:0] sz;
        begin
            case (sz)
                `DDC_SZ_BYTE: place = {4{d[7:0]}};
                `DDC_SZ_HALF: place = {2{d[15:0]}};
                default: place = d;
            endcase
        end
    endfunction

    // Merges a bus write into an old value under the byte enables.
    function [31:0] bmerge;
        input [31:0] o;
        input [31:0] n;
        input [3:0] s;
        begin
            bmerge = {s[3] ? n[31:24] : o[31:24], s[2] ? n[23:16] : o[23:16],
                      s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
        end
    endfunction

    // Arbiter of one controller: {valid, index}; highest level first, later loop
    // iterations overwrite earlier ones so the lowest index of the top level wins.
    function [3:0] arb;
        input [NCH-1:0] r;
        input [2*NCH-1:0] p;
        integer lv;
        integer i;
        begin
            arb = 4'h0;
            for (lv = 0; lv < 4; lv = lv + 1) begin
                for (i = NCH - 1; i >= 0; i = i - 1) begin
                    if (r[i] && p[2*i +: 2] == lv[1:0]) begin
                        arb = {1'b1, i[2:0]};
                    end
                end
            end
        end
    endfunction

    wire [3:0] s_ch = wb_adr_i[8:5];
    wire [2:0] s_rg = wb_adr_i[4:2];
    wire s_hit = wb_cyc_i && wb_stb_i && !wb_ack_q;
    wire s_map = s_ch < NT && s_rg <= `DDC_OFF_REM;
    wire s_wr = s_hit && wb_we_i && s_map;
    wire [31:0] cfg_wv = bmerge({16'h0, cfg_q[s_ch]}, wb_dat_i, wb_sel_i);
    wire [31:0] cnt_wv = bmerge({15'h0, cnt_q[s_ch]}, wb_dat_i, wb_sel_i);
    wire [15:0] ccfg = cfg_q[ch_q];
    wire [`DDC_CW-1:0] rem_n = rem_q[ch_q] - 1'b1;

    // Pending requests and priorities of every channel.
    always @* begin
        req = {NT{1'b0}};
        prio = {2*NT{1'b0}};
        for (k = 0; k < NT; k = k + 1) begin
            prio[2*k +: 2] = cfg_q[k][`DDC_CFG_PRIO];
            case (cfg_q[k][`DDC_CFG_TRIG])
                `DDC_TRIG_HW: req[k] = dreq_i[k];
                `DDC_TRIG_SW: req[k] = 1'b1;
                `DDC_TRIG_TMR: req[k] = tpend_q[k];
                default: req[k] = 1'b0;
            endcase
            req[k] = req[k] && cfg_q[k][`DDC_CFG_EN] && rem_q[k] != {`DDC_CW{1'b0}};
        end
    end

    always @* begin
        g0 = arb(req[NCH-1:0], prio[2*NCH-1:0]);
        g1 = arb(req[NT-1:NCH], prio[2*NT-1:2*NCH]);
        grant_v = g0[3] || g1[3];
        // Both controllers share one master port; they take turns when both ask.
        if (g0[3] && g1[3]) begin
            grant_ctl = !last_ctl_q;
        end else begin
            grant_ctl = g1[3];
        end
        if (grant_ctl) begin
            grant_ch = {1'b0, g1[2:0]} + NCH[3:0];
        end else begin
            grant_ch = {1'b0, g0[2:0]};
        end
    end

    // Register slave: one wait state, unmapped reads return zero and writes drop.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h0;
        end else begin
            wb_ack_q <= s_hit;
            wb_dat_q <= 32'h0;
            if (s_hit && !wb_we_i && s_map) begin
                case (s_rg)
                    `DDC_OFF_CFG: wb_dat_q <= {16'h0, cfg_q[s_ch]};
                    `DDC_OFF_CNT: wb_dat_q <= {15'h0, cnt_q[s_ch]};
                    `DDC_OFF_SRC: wb_dat_q <= src_q[s_ch];
                    `DDC_OFF_DST: wb_dat_q <= dst_q[s_ch];
                    `DDC_OFF_STAT: wb_dat_q <= {28'h0, irq_q[s_ch], flg_q[s_ch]};
                    default: wb_dat_q <= {15'h0, rem_q[s_ch]};
                endcase
            end
        end
    end

    // Channel state: software writes first, engine updates after so a flag
    // set by the engine wins over a clear in the same cycle.
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (k = 0; k < NT; k = k + 1) begin
                cfg_q[k] <= `DDC_CFG_RST;
                cnt_q[k] <= {`DDC_CW{1'b0}};
                src_q[k] <= 32'h0;
                dst_q[k] <= 32'h0;
                csrc_q[k] <= 32'h0;
                cdst_q[k] <= 32'h0;
                rem_q[k] <= {`DDC_CW{1'b0}};
                flg_q[k] <= 3'h0;
            end
            tpend_q <= {NT{1'b0}};
            irq_q <= {NT{1'b0}};
            dack_q <= {NT{1'b0}};
        end else begin
            dack_q <= {NT{1'b0}};
            // A grant consumes the pending timer item; a new pulse in that cycle is kept.
            if (st_q == ST_IDLE && grant_v) begin
                tpend_q[grant_ch] <= 1'b0;
            end
            for (k = 0; k < NT; k = k + 1) begin
                irq_q[k] <= |flg_q[k];
                if (timer_units_trig_i[k] && !stop_mode_i && cfg_q[k][`DDC_CFG_EN]
                    && cfg_q[k][`DDC_CFG_TRIG] == `DDC_TRIG_TMR) begin
                    tpend_q[k] <= 1'b1;
                end
            end
            if (s_wr) begin
                case (s_rg)
                    `DDC_OFF_CFG: begin
                        cfg_q[s_ch] <= cfg_wv[15:0];
                        // Enabling restarts the sequence from the programmed values.
                        if (cfg_wv[`DDC_CFG_EN] && !cfg_q[s_ch][`DDC_CFG_EN]) begin
                            rem_q[s_ch] <= cnt_q[s_ch];
                            csrc_q[s_ch] <= src_q[s_ch];
                            cdst_q[s_ch] <= dst_q[s_ch];
                        end
                    end
                    `DDC_OFF_CNT: begin
                        if (cnt_wv[`DDC_CW-1:0] > `DDC_CNT_MAX) begin
                            cnt_q[s_ch] <= `DDC_CNT_MAX;
                        end else begin
                            cnt_q[s_ch] <= cnt_wv[`DDC_CW-1:0];
                        end
                    end
                    `DDC_OFF_SRC: src_q[s_ch] <= bmerge(src_q[s_ch], wb_dat_i, wb_sel_i);
                    `DDC_OFF_DST: dst_q[s_ch] <= bmerge(dst_q[s_ch], wb_dat_i, wb_sel_i);
                    `DDC_OFF_STAT: flg_q[s_ch] <= flg_q[s_ch] & ~wb_dat_i[2:0];
                    default: ;
                endcase
            end
            if ((st_q == ST_RD || st_q == ST_WR) && m_err_i) begin
                flg_q[ch_q][`DDC_ST_TE] <= 1'b1;
                cfg_q[ch_q][`DDC_CFG_EN] <= 1'b0;
            end else if (st_q == ST_WR && m_ack_i) begin
                if (ccfg[`DDC_CFG_TRIG] == `DDC_TRIG_HW) begin
                    dack_q[ch_q] <= 1'b1;
                end
                if (ccfg[`DDC_CFG_SINC]) begin
                    csrc_q[ch_q] <= csrc_q[ch_q] + step(ccfg[`DDC_CFG_SSIZE]);
                end
                if (ccfg[`DDC_CFG_DINC]) begin
                    cdst_q[ch_q] <= cdst_q[ch_q] + step(ccfg[`DDC_CFG_DSIZE]);
                end
                rem_q[ch_q] <= rem_n;
                if (rem_n == (cnt_q[ch_q] >> 1)) begin
                    flg_q[ch_q][`DDC_ST_HT] <= 1'b1;
                end
                if (rem_n == {`DDC_CW{1'b0}}) begin
                    flg_q[ch_q][`DDC_ST_TC] <= 1'b1;
                    if (ccfg[`DDC_CFG_CIRC]) begin
                        rem_q[ch_q] <= cnt_q[ch_q];
                        csrc_q[ch_q] <= src_q[ch_q];
                        cdst_q[ch_q] <= dst_q[ch_q];
                    end else begin
                        cfg_q[ch_q][`DDC_CFG_EN] <= 1'b0;
                    end
                end
            end
        end
    end

    // Transfer engine: one item is read, the bus is released for a cycle, then
    // the item is written. Reads and writes are separate cycles so a slow
    // peripheral on either side never holds the other side's bus.
    // fourteen channels
    always @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            ch_q <= 4'h0;
            last_ctl_q <= 1'b0;
            buf_q <= 32'h0;
            m_cyc_q <= 1'b0;
            m_we_q <= 1'b0;
            m_adr_q <= 32'h0;
            m_sel_q <= 4'h0;
            m_dat_q <= 32'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (grant_v) begin
                        ch_q <= grant_ch;
                        last_ctl_q <= grant_ctl;
                        m_cyc_q <= 1'b1;
                        m_we_q <= 1'b0;
                        m_adr_q <= {csrc_q[grant_ch][31:2], 2'h0};
                        m_sel_q <= lanes(cfg_q[grant_ch][`DDC_CFG_SSIZE],
                                         csrc_q[grant_ch][1:0]);
                        st_q <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (m_err_i) begin
                        m_cyc_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end else if (m_ack_i) begin
                        buf_q <= extract(m_dat_i, ccfg[`DDC_CFG_SSIZE], csrc_q[ch_q][1:0]);
                        m_cyc_q <= 1'b0;
                        st_q <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    m_cyc_q <= 1'b1;
                    m_we_q <= 1'b1;
                    m_adr_q <= {cdst_q[ch_q][31:2], 2'h0};
                    m_sel_q <= lanes(ccfg[`DDC_CFG_DSIZE], cdst_q[ch_q][1:0]);
                    m_dat_q <= place(buf_q, ccfg[`DDC_CFG_DSIZE]);
                    st_q <= ST_WR;
                end
                default: begin
                    if (m_err_i || m_ack_i) begin
                        m_cyc_q <= 1'b0;
                        m_we_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;
    assign m_cyc_o = m_cyc_q;
    assign m_stb_o = m_cyc_q;
    assign m_we_o = m_we_q;
    assign m_adr_o = m_adr_q;
    assign m_sel_o = m_sel_q;
    assign m_dat_o = m_dat_q;
    assign dack_o = dack_q;
    assign irq_o = irq_q;

endmodule

// ---- tb/ddc_assertions.sv ----
`timescale 1ns/100ps
// Port checker for the transfer engine: register slave and bus master timing.
module ddc_checker #(
    parameter NCH = 7
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire m_cyc_o,
    input wire m_stb_o,
    input wire m_we_o,
    input wire [31:0] m_adr_o,
    input wire m_ack_i,
    input wire m_err_i,
    input wire [2*NCH-1:0] dack_o,
    input wire [2*NCH-1:0] irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Register accesses are answered one cycle later, for exactly one cycle.
    a_reg_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("register access not acked in the next cycle");
    a_reg_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("register ack longer than one cycle");
    // A master request must not move until the slave answers.
    a_bus_req_hold: assert property (m_cyc_o && !m_ack_i && !m_err_i |=>
        m_cyc_o && $stable(m_adr_o) && $stable(m_we_o))
        else $error("master request changed before its answer");
    a_bus_cyc_stb: assert property (m_cyc_o == m_stb_o)
        else $error("master cycle and strobe differ");
    // Each read item is followed by its write after one idle cycle.
    a_read_then_write: assert property (m_cyc_o && !m_we_o && m_ack_i |=>
        !m_cyc_o ##1 (m_cyc_o && m_we_o))
        else $error("read item not followed by its write");
    a_bus_idle_gap: assert property (m_cyc_o && m_we_o && (m_ack_i || m_err_i) |=> !m_cyc_o)
        else $error("no idle cycle after a write");
    a_dack_on_write: assert property (|dack_o |-> $past(m_cyc_o && m_we_o && m_ack_i))
        else $error("peripheral ack without a finished write");
    a_dack_single: assert property ($onehot0(dack_o))
        else $error("more than one channel served at once");
    a_err_to_irq: assert property (m_cyc_o && m_err_i |=> ##[0:2] (|irq_o))
        else $error("bus error raised no interrupt");

    c_err: cover property (m_cyc_o && m_err_i);
    c_dack: cover property (|dack_o);
    c_irq: cover property (|irq_o);
    c_copy: cover property (m_cyc_o && !m_we_o && m_ack_i ##2 m_cyc_o && m_we_o);
endmodule

bind ddc_top ddc_checker #(.NCH(NCH)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .m_cyc_o(m_cyc_o),
    .m_stb_o(m_stb_o), .m_we_o(m_we_o), .m_adr_o(m_adr_o), .m_ack_i(m_ack_i),
    .m_err_i(m_err_i), .dack_o(dack_o), .irq_o(irq_o));

// ---- tb/ddc_mem_model.sv ----
`timescale 1ns/100ps
// Memory on the system bus: programmable wait states and one address that errors.
module ddc_mem_model (
    input wire clk_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [31:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [3:0] wait_i,
    input wire [31:0] err_adr_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg err_o
);
    reg [31:0] mem [0:255];
    reg [3:0] cnt_q;
    integer i;
    initial begin
        dat_o = 32'h0;
        ack_o = 1'b0;
        err_o = 1'b0;
        cnt_q = 4'h0;
    end
    // Read data toggles outside an answer so a stale value is never mistaken for data.
    always @(posedge clk_i) begin
        dat_o <= ~dat_o;
        if (ack_o || err_o || !(cyc_i && stb_i)) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            cnt_q <= 4'h0;
        end else if (cnt_q < wait_i) begin
            cnt_q <= cnt_q + 4'h1;
        end else if (adr_i == err_adr_i) begin
            err_o <= 1'b1;
        end else begin
            ack_o <= 1'b1;
            dat_o <= mem[adr_i[9:2]];
            for (i = 0; i < 4; i = i + 1) begin
                if (we_i && sel_i[i]) mem[adr_i[9:2]][8*i +: 8] <= dat_i[8*i +: 8];
            end
        end
    end
endmodule

// ---- tb/ddc_top_tb_top.sv ----
`timescale 1ns/100ps
`include "ddc_consts.vh"
module ddc_top_tb_top;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [8:0] wb_adr_i = 9'h0;
    reg [31:0] wb_dat_i = 32'h0;
    reg [13:0] dreq_i = 14'h0;
    reg [13:0] trig_i = 14'h0;
    reg stop_mode_i = 1'b0;
    reg [3:0] mwait = 4'h0;
    reg [31:0] err_adr = 32'hffffffff;
    wire [31:0] wb_dat_o, m_adr_o, m_dat_o, m_dat_i;
    wire wb_ack_o, m_cyc_o, m_stb_o, m_we_o, m_ack_i, m_err_i;
    wire [3:0] m_sel_o;
    wire [13:0] dack_o, irq_o;
    reg [31:0] ref_mem [0:255];
    reg [31:0] lfsr_q = 32'hb707cac2;
    reg [31:0] rd;
    integer bad_count = 0, comparisons = 0, s, d, k, n, ch, sa, da;
    integer cs [0:14] = '{1, 2, 2, 2, 1, 1, 0, 3, 3, 3, 9, 1, 8, 1, 8};

    always #20 clk_i = ~clk_i;

    ddc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .m_cyc_o(m_cyc_o), .m_stb_o(m_stb_o),
        .m_we_o(m_we_o), .m_adr_o(m_adr_o), .m_sel_o(m_sel_o), .m_dat_o(m_dat_o),
        .m_dat_i(m_dat_i), .m_ack_i(m_ack_i), .m_err_i(m_err_i), .dreq_i(dreq_i),
        .dack_o(dack_o), .timer_units_trig_i(trig_i), .stop_mode_i(stop_mode_i),
        .irq_o(irq_o));
    ddc_mem_model mem (.clk_i(clk_i), .cyc_i(m_cyc_o), .stb_i(m_stb_o), .we_i(m_we_o),
        .adr_i(m_adr_o), .sel_i(m_sel_o), .dat_i(m_dat_o), .wait_i(mwait),
        .err_adr_i(err_adr), .dat_o(m_dat_i), .ack_o(m_ack_i), .err_o(m_err_i));

    function [31:0] rnd(input [31:0] v);
        rnd = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function [8:0] ra(input integer c, input [2:0] off);
        ra = {c[3:0], off, 2'b00};
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // One classic cycle; held until ack is sampled, released at that same edge.
    task wb(input we, input [8:0] a, input [31:0] v);
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= a;
            wb_dat_i <= v;
            // Only the watchdog ends a wait for the answer.
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1) begin
                @(posedge clk_i);
            end
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask
    // Polls a channel's status until any of the given bits is set.
    task poll(input integer c, input [31:0] m);
        begin
            n = 0;
            rd = 0;
            while ((rd & m) == 0 && n < 400) begin
                wb(0, ra(c, `DDC_OFF_STAT), 0);
                n = n + 1;
            end
        end
    endtask
    task setup(input integer c, input [31:0] cnt, input [31:0] sr, input [31:0] ds,
               input [31:0] cfg);
        begin
            wb(1, ra(c, `DDC_OFF_CNT), cnt);
            wb(1, ra(c, `DDC_OFF_SRC), sr);
            wb(1, ra(c, `DDC_OFF_DST), ds);
            wb(1, ra(c, `DDC_OFF_CFG), cfg);
        end
    endtask
    // Reference copy of one item with width conversion.
    task move(input [31:0] a, input [1:0] sz, input [31:0] b, input [1:0] dz);
        reg [31:0] v;
        integer i;
        begin
            v = ref_mem[a[9:2]] >> (8 * a[1:0]);
            for (i = 0; i < (1 << dz); i = i + 1) begin
                ref_mem[b[9:2]][8 * (b[1:0] + i) +: 8] = (i < (1 << sz)) ? v[8*i +: 8] : 8'h0;
            end
        end
    endtask
    task summarize;
        begin
            $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    // Watchdog well above the expected run length.
    initial begin
        #(40 * 60000);
        bad_count = bad_count + 1;
        summarize;
    end

    initial begin
        for (k = 0; k < 256; k = k + 1) begin
            lfsr_q = rnd(lfsr_q);
            mem.mem[k] = lfsr_q;
            ref_mem[k] = lfsr_q;
        end
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, ra(0, `DDC_OFF_CFG), 0);
        chk(rd, {16'h0, `DDC_CFG_RST});
        wb(1, 9'h1c0, 32'h5a5a5a5a);
        wb(0, 9'h1c0, 0);
        chk(rd, 32'h0);
        wb(1, ra(13, `DDC_OFF_REM), 32'h7);
        wb(0, ra(13, `DDC_OFF_REM), 0);
        chk(rd, 32'h0);
        wb(1, ra(13, `DDC_OFF_CNT), 32'h1ffff);
        wb(0, ra(13, `DDC_OFF_CNT), 0);
        chk(rd, 32'h10000);
        // Software copies over every width pair, slow memory, on both controllers.
        mwait <= 4'hf;
        for (s = 0; s < 3; s = s + 1) for (d = 0; d < 3; d = d + 1) begin
            ch = 3 * s + d;
            lfsr_q = rnd(lfsr_q);
            sa = lfsr_q[5:0] & ~((1 << s) - 1);
            da = 32'h200 + (lfsr_q[13:8] & ~((1 << d) - 1));
            setup(ch, 4, sa, da, 32'h701 | lfsr_q[17:16] << 2 | s << 4 | d << 6);
            poll(ch, 32'h3);
            chk(rd & 32'h7, 32'h1);
            wb(0, ra(ch, `DDC_OFF_REM), 0);
            chk(rd, 32'h2);
            poll(ch, 32'h2);
            wb(0, ra(ch, `DDC_OFF_STAT), 0);
            chk(rd, 32'hb);
            chk(irq_o[ch], 1'b1);
            wb(0, ra(ch, `DDC_OFF_CFG), 0);
            chk(rd[0], 1'b0);
            for (k = 0; k < 4; k = k + 1) move(sa + (k << s), s, da + (k << d), d);
            wb(1, ra(ch, `DDC_OFF_STAT), 32'h7);
            @(posedge clk_i);
            chk(irq_o[ch], 1'b0);
        end
        for (k = 0; k < 256; k = k + 1) chk(mem.mem[k], ref_mem[k]);
        // Peripheral requests raised together: priority, then lower number first.
        for (k = 0; k < 15; k = k + 5) begin
            lfsr_q = rnd(lfsr_q);
            mwait <= lfsr_q[1:0];
            setup(cs[k], 1, 32'h40, 32'h300, 32'ha1 | cs[k+1] << 2);
            setup(cs[k+2], 1, 32'h40, 32'h300, 32'ha1 | cs[k+3] << 2);
            @(posedge clk_i);
            dreq_i <= (14'h1 << cs[k]) | (14'h1 << cs[k+2]);
            n = 0;
            while (dack_o == 0 && n < 200) begin
                @(posedge clk_i);
                n = n + 1;
            end
            chk(dack_o, 14'h1 << cs[k+4]);
            dreq_i <= dreq_i & ~dack_o;
            while (dreq_i != 0 && n < 400) begin
                @(posedge clk_i);
                if (dack_o != 0) dreq_i <= dreq_i & ~dack_o;
                n = n + 1;
            end
            chk(dreq_i, 14'h0);
            wb(1, ra(cs[k], `DDC_OFF_STAT), 7);
            wb(1, ra(cs[k+2], `DDC_OFF_STAT), 7);
        end
        move(32'h40, 2, 32'h300, 2);
        // Timer trigger ignored in stop mode, honoured in run mode.
        setup(10, 1, 32'h44, 32'h304, 32'ha0 | `DDC_TRIG_TMR << 10 | 1);
        stop_mode_i <= 1'b1;
        trig_i <= 14'h400;
        @(posedge clk_i);
        trig_i <= 14'h0;
        repeat (60) @(posedge clk_i);
        wb(0, ra(10, `DDC_OFF_REM), 0);
        chk(rd, 32'h1);
        stop_mode_i <= 1'b0;
        trig_i <= 14'h400;
        @(posedge clk_i);
        trig_i <= 14'h0;
        poll(10, 32'h2);
        chk(rd[1], 1'b1);
        move(32'h44, 2, 32'h304, 2);
        // Bus error on the first read halts the channel.
        err_adr <= 32'h48;
        setup(11, 2, 32'h48, 32'h308, 32'h7a1);
        poll(11, 32'h4);
        chk(rd & 32'h7, 32'h4);
        wb(0, ra(11, `DDC_OFF_CFG), 0);
        chk(rd[0], 1'b0);
        chk(irq_o[11], 1'b1);
        err_adr <= 32'hffffffff;
        // Circular copy keeps running after its count is used up.
        setup(12, 2, 32'h50, 32'h310, 32'h7a3);
        poll(12, 32'h2);
        wb(0, ra(12, `DDC_OFF_CFG), 0);
        chk(rd[0], 1'b1);
        wb(1, ra(12, `DDC_OFF_CFG), 0);
        repeat (40) @(posedge clk_i);
        move(32'h50, 2, 32'h310, 2);
        move(32'h54, 2, 32'h314, 2);
        for (k = 0; k < 256; k = k + 1) chk(mem.mem[k], ref_mem[k]);
        summarize;
    end
endmodule
